// File: scp_uart.sv
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "scp_defines.svh"

// Functional notes
// - five check modes in the mode field; two field codes (6 and 7) select multidrop instead.
// - even mode sends check bit 0 for even ones count, 1 for odd.
// - even/odd receive: flag error when sampled bit differs from predicted value.
// - odd mode sends check bit 1 for even ones count, 0 for odd.
// - mark mode always sends 1; receiving a 0 is an error.
// - space mode always sends 0; receiving a 1 is an error.
// - no check mode: no check bit sent, never an error reported.
// - detected error sets a status flag that stays until software clears it.
// - writing control with the status clear bit at one drops the flag.
module scp_uart
  import scp_pkg::*;
(
  input wire logic aclk, // 200 MHz clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic rxd, // serial input pin
  output logic txd, // serial output pin
  output logic irq // level interrupt
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] sel;
    logic [1:0] len;
    logic [5:0] mask;
    logic [5:0] status;
    logic [15:0] div;
    logic send_addr;
    logic irq;
    scp_tx_state_t tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_check;
    logic txd;
    logic rx_s1;
    logic rx_s2;
    scp_rx_state_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_check;
    logic [7:0] rx_data;
    logic rx_full;
  } scp_state_t;

  scp_state_t state_reg;
  scp_state_t state_next;
  logic gen_bit;
  logic chk_err;
  logic chk_addr;

  // check bit for the character held in the write data latch
  scp_check_gen u_gen (
    .char_data(state_reg.w_data[7:0]),
    .char_len(state_reg.len),
    .sel(state_reg.sel),
    .send_addr(state_reg.send_addr),
    .check_bit(gen_bit)
  );

  // verdict on the character being received
  scp_check_chk u_chk (
    .char_data(state_reg.rx_shift),
    .char_len(state_reg.len),
    .sel(state_reg.sel),
    .check_bit(state_reg.rx_check),
    .check_err(chk_err),
    .addr_seen(chk_addr)
  );

  // byte-lane merge for registers wider than one byte
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction
  // readback of one register word, zero above the implemented bits
  function automatic logic [31:0] read_word(input scp_state_t s, input logic [7:0] a);
    read_word = 32'h0000_0000;
    unique case (a)
      `SCP_OFS_MODE: read_word = {26'h0, s.len, 1'b0, s.sel};
      `SCP_OFS_STAT: read_word = {22'h0, s.rx_full, s.tx_st != TX_IDLE, 2'h0, s.status};
      `SCP_OFS_MASK: read_word = {26'h0, s.mask};
      `SCP_OFS_DIV: read_word = {16'h0, s.div};
      `SCP_OFS_RXD: read_word = {24'h0, s.rx_data};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction
  // unmapped addresses answer with an error
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `SCP_OFS_CTRL) || (a == `SCP_OFS_MODE) || (a == `SCP_OFS_STAT) ||
              (a == `SCP_OFS_MASK) || (a == `SCP_OFS_DIV) || (a == `SCP_OFS_TXD) ||
              (a == `SCP_OFS_RXD);
  endfunction
  // whole next state in one place
  always_comb
  begin
    logic wr_fire;
    logic [5:0] set_bits;
    logic [5:0] clr_bits;
    logic rd_rxd;
    logic [15:0] div_m1;
    wr_fire = 1'b0;
    set_bits = 6'h00;
    clr_bits = 6'h00;
    rd_rxd = 1'b0;
    div_m1 = state_reg.div - 16'h0001;
    state_next = state_reg;
    // write address and data are caught independently, in either order
    if (awvalid && state_reg.awready)
    begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = {awaddr[7:2], 2'h0};
    end
    if (wvalid && state_reg.wready)
    begin
      state_next.w_got = 1'b1;
      state_next.w_data = wdata;
      state_next.w_strb = wstrb;
    end
    if (bvalid && bready)
      state_next.bvalid = 1'b0;
    // both halves held: perform the write, answer next cycle
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid)
    begin
      wr_fire = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = addr_ok(state_reg.aw_addr) ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
    end

    if (wr_fire && state_reg.w_strb[0])
    begin
      unique case (state_reg.aw_addr)
        `SCP_OFS_CTRL:
        begin
          if (state_reg.w_data[`SCP_CTRL_STATUS_CLEAR])
          begin
            clr_bits[`SCP_ST_CHECK_ERR] = 1'b1;
            clr_bits[`SCP_ST_OVERRUN] = 1'b1;
            clr_bits[`SCP_ST_FRAME_ERR] = 1'b1;
            clr_bits[`SCP_ST_ADDR_RCVD] = 1'b1;
          end
          state_next.send_addr = state_reg.w_data[`SCP_CTRL_SEND_ADDR];
        end
        `SCP_OFS_MODE:
        begin
          state_next.sel = state_reg.w_data[`SCP_MODE_SEL_LSB +: 3];
          state_next.len = state_reg.w_data[`SCP_MODE_LEN_LSB +: 2];
        end
        `SCP_OFS_STAT: clr_bits = state_reg.w_data[5:0]; // write one to clear
        `SCP_OFS_MASK: state_next.mask = state_reg.w_data[5:0];
        default: ;
      endcase
    end
    if (wr_fire && state_reg.aw_addr == `SCP_OFS_DIV)
      state_next.div = merge16(state_reg.div, state_reg.w_data, state_reg.w_strb);
    // a character written while the sender is busy is dropped
    if (wr_fire && state_reg.w_strb[0] && state_reg.aw_addr == `SCP_OFS_TXD &&
        state_reg.tx_st == TX_IDLE)
    begin
      state_next.tx_shift = scp_char_mask(state_reg.w_data[7:0], state_reg.len);
      state_next.tx_check = gen_bit;
      state_next.tx_st = TX_START;
      state_next.tx_cnt = div_m1;
      state_next.txd = 1'b0;
    end
    // read channel: one read at a time, data ready the cycle after acceptance
    if (rvalid && rready)
      state_next.rvalid = 1'b0;
    if (arvalid && state_reg.arready)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_word(state_reg, {araddr[7:2], 2'h0});
      state_next.rresp = addr_ok({araddr[7:2], 2'h0}) ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
      rd_rxd = {araddr[7:2], 2'h0} == `SCP_OFS_RXD;
    end
    if (rd_rxd)
      state_next.rx_full = 1'b0;
    // sender: start, data lsb first, check bit, one stop bit
    if (state_reg.tx_st != TX_IDLE)
    begin
      if (state_reg.tx_cnt != 16'h0000)
        state_next.tx_cnt = state_reg.tx_cnt - 16'h0001;
      else
      begin
        state_next.tx_cnt = div_m1;
        unique case (state_reg.tx_st)
          TX_START:
          begin
            state_next.tx_st = TX_DATA;
            state_next.tx_bit = 3'h0;
            state_next.txd = state_reg.tx_shift[0];
          end
          TX_DATA:
          begin
            if (state_reg.tx_bit == {1'b1, state_reg.len})
            begin
              if (scp_has_check(state_reg.sel))
              begin
                state_next.tx_st = TX_CHECK; // check bit follows last data bit
                state_next.txd = state_reg.tx_check;
              end
              else
              begin
                state_next.tx_st = TX_STOP; // no check bit in the frame
                state_next.txd = 1'b1;
              end
            end
            else
            begin
              state_next.tx_bit = state_reg.tx_bit + 3'h1;
              state_next.txd = state_reg.tx_shift[state_reg.tx_bit + 3'h1];
            end
          end
          TX_CHECK:
          begin
            state_next.tx_st = TX_STOP;
            state_next.txd = 1'b1;
          end
          TX_STOP:
          begin
            state_next.tx_st = TX_IDLE;
            set_bits[`SCP_ST_TX_DONE] = 1'b1;
          end
          TX_IDLE: ;
        endcase
      end
    end
    // pin synchroniser; only the second stage is looked at
    state_next.rx_s1 = rxd;
    state_next.rx_s2 = state_reg.rx_s1;
    // receiver samples mid-bit, half a period after the start edge
    unique case (state_reg.rx_st)
      RX_IDLE:
      begin
        if (!state_reg.rx_s2)
        begin
          state_next.rx_st = RX_START;
          state_next.rx_cnt = state_reg.div >> 1;
        end
      end
      default:
      begin
        if (state_reg.rx_cnt != 16'h0000)
          state_next.rx_cnt = state_reg.rx_cnt - 16'h0001;
        else
        begin
          state_next.rx_cnt = div_m1;
          unique case (state_reg.rx_st)
            RX_START:
            begin
              // a glitch shorter than half a bit is not a start
              state_next.rx_st = state_reg.rx_s2 ? RX_IDLE : RX_DATA;
              state_next.rx_bit = 3'h0;
              state_next.rx_shift = 8'h00;
            end
            RX_DATA:
            begin
              state_next.rx_shift[state_reg.rx_bit] = state_reg.rx_s2;
              state_next.rx_bit = state_reg.rx_bit + 3'h1;
              if (state_reg.rx_bit == {1'b1, state_reg.len})
                state_next.rx_st = scp_has_check(state_reg.sel) ? RX_CHECK : RX_STOP;
            end
            RX_CHECK:
            begin
              state_next.rx_check = state_reg.rx_s2;
              state_next.rx_st = RX_STOP;
            end
            RX_STOP:
            begin
              state_next.rx_st = RX_IDLE;
              state_next.rx_data = state_reg.rx_shift;
              state_next.rx_full = 1'b1;
              set_bits[`SCP_ST_RX_DONE] = 1'b1;
              set_bits[`SCP_ST_OVERRUN] = state_reg.rx_full && !rd_rxd;
              set_bits[`SCP_ST_FRAME_ERR] = !state_reg.rx_s2;
              set_bits[`SCP_ST_CHECK_ERR] = chk_err;
              set_bits[`SCP_ST_ADDR_RCVD] = chk_addr;
            end
            RX_IDLE: ;
          endcase
        end
      end
    endcase
    if (state_reg.rx_st == RX_IDLE || state_reg.rx_st == RX_START)
      state_next.rx_check = 1'b0;

    // sticky flags: a new event wins over a clear in the same cycle
    state_next.status = (state_reg.status & ~clr_bits) | set_bits;
    state_next.irq = |(state_next.status & state_next.mask);

    // ready again only once the previous transfer is fully answered
    state_next.awready = !state_next.aw_got && !state_next.bvalid;
    state_next.wready = !state_next.w_got && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;
  end

  // single register bank for all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.sel <= `SCP_RST_SEL;
      state_reg.len <= `SCP_RST_LEN;
      state_reg.mask <= `SCP_RST_MASK;
      state_reg.div <= `SCP_RST_DIV;
      state_reg.txd <= 1'b1;
      state_reg.rx_s1 <= 1'b1;
      state_reg.rx_s2 <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // all outputs straight from the state register
  assign awready = state_reg.awready;
  assign wready = state_reg.wready;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign arready = state_reg.arready;
  assign rvalid = state_reg.rvalid;
  assign rdata = state_reg.rdata;
  assign rresp = state_reg.rresp;
  assign txd = state_reg.txd;
  assign irq = state_reg.irq;

endmodule

// File: scp_defines.svh
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// register byte offsets
`define SCP_OFS_CTRL 8'h00
`define SCP_OFS_MODE 8'h04
`define SCP_OFS_STAT 8'h08
`define SCP_OFS_MASK 8'h0C
`define SCP_OFS_DIV 8'h10
`define SCP_OFS_TXD 8'h14
`define SCP_OFS_RXD 8'h18

// line_control_register bits
`define SCP_CTRL_STATUS_CLEAR 0
`define SCP_CTRL_SEND_ADDR 1

// line_mode_register fields
`define SCP_MODE_SEL_LSB 0
`define SCP_MODE_LEN_LSB 4

// channel_status_register bits: sticky events, then live busy and full
`define SCP_ST_RX_DONE 0
`define SCP_ST_TX_DONE 1
`define SCP_ST_OVERRUN 2
`define SCP_ST_FRAME_ERR 3
`define SCP_ST_CHECK_ERR 4
`define SCP_ST_ADDR_RCVD 5
`define SCP_ST_TX_BUSY 8
`define SCP_ST_RX_FULL 9

// check_bit_select encodings
`define SCP_SEL_EVEN 3'h0
`define SCP_SEL_ODD 3'h1
`define SCP_SEL_SPACE 3'h2
`define SCP_SEL_MARK 3'h3
`define SCP_SEL_NONE 3'h4

// reset values
`define SCP_RST_SEL 3'h4
`define SCP_RST_LEN 2'h3
`define SCP_RST_MASK 6'h00
`define SCP_RST_DIV 16'h06C8

// bus answers
`define SCP_RESP_OKAY 2'h0
`define SCP_RESP_SLVERR 2'h2

`endif

// File: scp_pkg.sv
package scp_pkg;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_CHECK, TX_STOP} scp_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_CHECK, RX_STOP} scp_rx_state_t;

  // check bit present for every code except the two "none" codes
  function automatic logic scp_has_check(input logic [2:0] sel);
    scp_has_check = !(sel[2] && !sel[1]);
  endfunction

  // codes 6 and 7 carry the address/data marker in the check bit slot
  function automatic logic scp_is_multidrop(input logic [2:0] sel);
    scp_is_multidrop = sel[2] && sel[1];
  endfunction

  // keep only the data bits of a 5..8 bit character
  function automatic logic [7:0] scp_char_mask(input logic [7:0] ch, input logic [1:0] len);
    scp_char_mask = ch & (8'hFF >> (2'h3 - len));
  endfunction

endpackage

// File: scp_check_gen.sv
`timescale 1ns/100ps
`include "scp_defines.svh"

module scp_check_gen
  import scp_pkg::*;
(
  input wire logic [7:0] char_data, // character to send
  input wire logic [1:0] char_len, // data bits minus five
  input wire logic [2:0] sel, // check_bit_select
  input wire logic send_addr, // multidrop address marker
  output logic check_bit // bit placed after the data
);

  logic ones_odd;

  // odd count of ones over the valid data bits only
  assign ones_odd = ^scp_char_mask(char_data, char_len);

  always_comb
  begin
    if (scp_is_multidrop(sel))
      check_bit = send_addr;
    else
      unique case (sel)
        `SCP_SEL_EVEN: check_bit = ones_odd;
        `SCP_SEL_ODD: check_bit = !ones_odd;
        `SCP_SEL_MARK: check_bit = 1'b1;
        default: check_bit = 1'b0; // space, and unused for none
      endcase
  end

endmodule

// File: scp_check_chk.sv
`timescale 1ns/100ps
`include "scp_defines.svh"

module scp_check_chk
  import scp_pkg::*;
(
  input wire logic [7:0] char_data, // received character
  input wire logic [1:0] char_len, // data bits minus five
  input wire logic [2:0] sel, // check_bit_select
  input wire logic check_bit, // sampled check bit
  output logic check_err, // sampled bit disagrees
  output logic addr_seen // multidrop address marker
);

  logic ones_odd;

  assign ones_odd = ^scp_char_mask(char_data, char_len);
  assign addr_seen = scp_is_multidrop(sel) && check_bit;

  // compare the sampled bit with what the mode predicts
  always_comb
  begin
    unique case (sel)
      `SCP_SEL_EVEN: check_err = check_bit != ones_odd;
      `SCP_SEL_ODD: check_err = check_bit == ones_odd;
      `SCP_SEL_MARK: check_err = !check_bit;
      `SCP_SEL_SPACE: check_err = check_bit;
      default: check_err = 1'b0; // none and multidrop never flag
    endcase
  end

endmodule

// File: scp_uart_props.sv
`timescale 1ns/100ps
`include "scp_defines.svh"

// port-level timing of the bus answers and idle pins
module scp_uart_props (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic txd, // serial out
  input wire logic irq // interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // answers stand until the master takes them
  a_wresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed before taken");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  a_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_latency: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:2] bvalid)
    else $error("write answer late");
  // one transfer of each kind at a time
  a_read_blocked: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  a_write_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_resp_codes: assert property ((bvalid || rvalid) |->
    (bresp == `SCP_RESP_OKAY || bresp == `SCP_RESP_SLVERR) &&
    (rresp == `SCP_RESP_OKAY || rresp == `SCP_RESP_SLVERR))
    else $error("illegal response code");
  // line idles high and nothing pending right after reset
  a_idle_reset: assert property ($rose(aresetn) |-> txd && !irq)
    else $error("not idle after reset");

  c_slverr: cover property (bvalid && bready && bresp == `SCP_RESP_SLVERR);
  c_irq: cover property ($rose(irq));
  c_frame: cover property ($fell(txd));
endmodule

bind scp_uart scp_uart_props props_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .txd(txd), .irq(irq));

// File: scp_remote.sv
`timescale 1ns/100ps

// far end of the serial line
module scp_remote (
  input wire logic clk, // shared clock
  input wire logic line_in, // block serial output
  output logic line_out, // block serial input
  input wire logic [15:0] div, // cycles per bit
  input wire logic [3:0] nbits, // data bits per character
  input wire logic use_chk // frame carries a check bit
);
  logic [9:0] frame;
  logic [9:0] got_q[$];

  initial line_out = 1'b1;

  // receive: mid-bit samples, data lsb first, then check, then stop
  always @(negedge line_in)
  begin
    frame = 10'h000;
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++)
    begin
      repeat (div) @(posedge clk);
      frame[i] = line_in;
    end
    if (use_chk)
    begin
      repeat (div) @(posedge clk);
      frame[8] = line_in;
    end
    repeat (div) @(posedge clk);
    frame[9] = line_in;
    got_q.push_back(frame);
  end

  // send: idle gap of choice, line back to idle high after stop
  task automatic send(input logic [7:0] ch, input logic chk, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    line_out <= 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      repeat (div) @(posedge clk);
      line_out <= ch[i];
    end
    if (use_chk)
    begin
      repeat (div) @(posedge clk);
      line_out <= chk;
    end
    repeat (div) @(posedge clk);
    line_out <= 1'b1;
    repeat (div) @(posedge clk);
  endtask
endmodule

// File: tb_serial_char_parity_unit.sv
`timescale 1ns/100ps
`include "scp_defines.svh"

module tb_serial_char_parity_unit;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rxd, txd, irq, p_chk, err_m, addr_m;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, p_bits;
  logic [1:0] bresp, rresp;
  int failures, n_checks;
  int unsigned seed;

  scp_uart dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd(rxd), .txd(txd), .irq(irq));
  scp_remote remote_u (.clk(aclk), .line_in(txd), .line_out(rxd), .div(16'h0004),
    .nbits(p_bits), .use_chk(p_chk));

  // 5 ns clock
  always #2.5 aclk = ~aclk;

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected check bit; multidrop carries the address marker
  function automatic logic pred(input logic [2:0] sel, input logic [7:0] ch, input logic sa);
    int ones;
    ones = 0;
    for (int i = 0; i < 8; i++) ones += ch[i];
    case (sel)
      `SCP_SEL_EVEN: return ones[0];
      `SCP_SEL_ODD: return !ones[0];
      `SCP_SEL_SPACE: return 1'b0;
      `SCP_SEL_MARK: return 1'b1;
      default: return sa;
    endcase
  endfunction

  task automatic print_verdict();
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic timeout();
    failures++;
    $display("ERROR %0t wait ran out", $time);
    print_verdict();
  endtask

  // write: offer address and data together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 200)
        timeout();
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    chk_word({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 200)
        timeout();
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    chk_word({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask

  // poll one status bit until it reaches a level
  task automatic wait_stat(input int b, input logic v);
    logic [31:0] d;
    int n;
    n = 0;
    rd(`SCP_OFS_STAT, d, `SCP_RESP_OKAY);
    while (d[b] !== v)
    begin
      n++;
      if (n > 300)
        timeout();
      rd(`SCP_OFS_STAT, d, `SCP_RESP_OKAY);
    end
  endtask

  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [9:0] f;
    logic [7:0] ch;
    logic [2:0] sel;
    logic [1:0] len;
    logic sa, c;
    int n;
    aclk = 0;
    aresetn = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    {failures, n_checks, seed} = {32'd0, 32'd0, 32'd87};
    {p_bits, p_chk, err_m, addr_m} = {4'h8, 3'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SCP_OFS_MODE, d, `SCP_RESP_OKAY);
    chk_word(d, {26'h0, `SCP_RST_LEN, 1'b0, `SCP_RST_SEL});
    rd(`SCP_OFS_DIV, d, `SCP_RESP_OKAY);
    chk_word(d, {16'h0, `SCP_RST_DIV});
    rd(8'h1C, d, `SCP_RESP_SLVERR);
    chk_word(d, 32'h0);
    wr(8'h1C, 32'hFFFF_FFFF, `SCP_RESP_SLVERR);
    wr(`SCP_OFS_DIV, 32'h4, `SCP_RESP_OKAY);
    wr(`SCP_OFS_MASK, 32'h10, `SCP_RESP_OKAY);
    // transmit every select code with random characters and lengths
    for (int k = 0; k < 16; k++)
    begin
      sel = 3'(k % 8);
      len = 2'(xs());
      ch = 8'(xs()) & (8'hFF >> (3 - int'(len)));
      sa = 1'(xs());
      p_bits = 4'(5 + int'(len));
      p_chk = !(sel == 3'h4 || sel == 3'h5);
      wr(`SCP_OFS_CTRL, {30'h0, sa, 1'b0}, `SCP_RESP_OKAY);
      wr(`SCP_OFS_MODE, {26'h0, len, 1'b0, sel}, `SCP_RESP_OKAY);
      wr(`SCP_OFS_TXD, {24'h0, ch}, `SCP_RESP_OKAY);
      n = 0;
      while (remote_u.got_q.size() == 0)
      begin
        @(posedge aclk);
        n++;
        if (n > 2000)
          timeout();
      end
      f = remote_u.got_q.pop_front();
      chk_word({24'h0, f[7:0]}, {24'h0, ch});
      if (p_chk)
        chk_bit(f[8], pred(sel, ch, sa));
      chk_bit(f[9], 1'b1);
      wait_stat(`SCP_ST_TX_BUSY, 1'b0);
    end
    // receive: second pass sends a wrong check bit in codes 0 to 3 (even, odd, space, mark)
    for (int k = 0; k < 24; k++)
    begin
      sel = 3'(k % 8);
      len = 2'(xs());
      ch = 8'(xs()) & (8'hFF >> (3 - int'(len)));
      c = pred(sel, ch, 1'(xs())) ^ (k / 8 == 1 && sel < 3'h4);
      p_bits = 4'(5 + int'(len));
      p_chk = !(sel == 3'h4 || sel == 3'h5);
      if (sel < 3'h4 && c !== pred(sel, ch, 1'b0))
        err_m = 1'b1;
      if (sel > 3'h5 && c)
        addr_m = 1'b1;
      wr(`SCP_OFS_MODE, {26'h0, len, 1'b0, sel}, `SCP_RESP_OKAY);
      remote_u.send(ch, c, int'(xs() % 5));
      wait_stat(`SCP_ST_RX_FULL, 1'b1);
      rd(`SCP_OFS_RXD, d, `SCP_RESP_OKAY);
      chk_word(d, {24'h0, ch});
      rd(`SCP_OFS_STAT, d, `SCP_RESP_OKAY);
      chk_bit(d[`SCP_ST_CHECK_ERR], err_m);
      chk_bit(d[`SCP_ST_ADDR_RCVD], addr_m);
      chk_bit(irq, err_m);
      if (xs() % 3 == 0)
      begin
        wr(`SCP_OFS_CTRL, 32'h1, `SCP_RESP_OKAY);
        {err_m, addr_m} = 2'b00;
        rd(`SCP_OFS_STAT, d, `SCP_RESP_OKAY);
        chk_bit(d[`SCP_ST_CHECK_ERR], 1'b0);
      end
    end
    // interrupt raised, masked, then cleared by write-one
    p_bits = 4'h8;
    p_chk = 1'b1;
    wr(`SCP_OFS_MODE, 32'h30, `SCP_RESP_OKAY);
    remote_u.send(8'h41, 1'b1, 0);
    wait_stat(`SCP_ST_RX_FULL, 1'b1);
    rd(`SCP_OFS_RXD, d, `SCP_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b1);
    wr(`SCP_OFS_MASK, 32'h0, `SCP_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
    wr(`SCP_OFS_STAT, 32'h10, `SCP_RESP_OKAY);
    rd(`SCP_OFS_STAT, d, `SCP_RESP_OKAY);
    chk_bit(d[`SCP_ST_CHECK_ERR], 1'b0);
    print_verdict();
  end
endmodule
